// file: rtl/dcf_mem.sv
// word array of the fifo, one write port and one asynchronous read port
`timescale 1ns/1ps
`include "dcf_defines.svh"
module dcf_mem #(
  parameter int WIDTH = `DCF_WIDTH,
  parameter int DEPTH = `DCF_DEPTH
) (
  input wire logic mclk,
  input wire logic wr_en,
  input wire logic [$clog2(DEPTH)-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic [$clog2(DEPTH)-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);

  // no reset on the array: contents are only trusted behind the pointers
  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge mclk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  assign rd_data = mem[rd_addr];

endmodule : dcf_mem

// file: rtl/dcf_top.sv
// dual-clock fifo with programmable almost-boundary, half-level and ready flags
// Contract
// - store up to 1024 words of 18 bits, written and read independently.
// - read words equal written words bit for bit, no inversion.
// - writes follow write clock, reads follow read clock, clocks independent.
// - almost flag high when level <= offset+1 or level >= 1025-offset.
// - almost flag low when level lies from offset+2 to 1024-offset.
// - falling offset load strobe captures write data bits 8..0 as offset.
// - reset release with strobe low applies the stored offset.
// - keeping the strobe low reuses the stored offset at next reset.
// - strobe high through reset applies default offset 256.
// - half flag high at 512 or more words, else low.
// - write-room flag high while not full, low while full.
// - during reset write-room flag drops on second write clock edge.
// - after reset release write-room flag rises on second write clock edge.
// - after full, write-room flag rises on second write edge after a read.
// - output drive enable low floats all 18 read data outputs.
// - a word is read only if output drive enable is high beforehand.
// - accept 18-bit words on the write data inputs.
// - write only when write-room flag and both write enables are high.
// - read only when read-available, drive enable and both read enables high.
// - read-available flag high while not empty, low while empty, on read clock.
`timescale 1ns/1ps
`include "dcf_defines.svh"
module dcf_top #(
  parameter int WIDTH = `DCF_WIDTH,
  parameter int DEPTH = `DCF_DEPTH
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic write_clock,
  input wire logic read_clock,
  input wire logic fifo_rst_n,
  input wire logic offset_load_strobe,
  input wire logic write_enable_a,
  input wire logic write_enable_b,
  input wire logic read_enable_a,
  input wire logic read_enable_b,
  input wire logic out_drive_en,
  input wire logic [WIDTH-1:0] write_data_bus,
  output logic [WIDTH-1:0] read_data_bus,
  output logic read_data_oe,
  output logic write_room_flag,
  output logic read_avail_flag,
  output logic half_level_flag,
  output logic almost_boundary_flag,
  input wire logic [`DCF_ADDR_W-1:0] reg_addr,
  input wire logic [`DCF_DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [`DCF_DATA_W-1:0] reg_rdata
);
  import dcf_pkg::*;

  localparam int PW = $clog2(DEPTH);
  localparam int LW = PW + 1;
  localparam int OW = `DCF_OFS_W;
  localparam logic [LW-1:0] DEPTH_L = LW'(DEPTH);
  localparam logic [LW-1:0] HALF_L = LW'(DEPTH / 2);
  localparam logic [1:0] AVAIL_LAST = 2'(`DCF_AVAIL_EDGES - 1);

  // ==========================================================
  // clock pins are sampled as data; one-cycle edge strobes
  logic wclk_ff, rclk_ff, strobe_ff;
  logic wr_edge, rd_edge, strobe_fall;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      wclk_ff <= 1'b0;
      rclk_ff <= 1'b0;
      strobe_ff <= 1'b1;
    end else begin
      wclk_ff <= write_clock;
      rclk_ff <= read_clock;
      strobe_ff <= offset_load_strobe;
    end
  end

  assign wr_edge = write_clock & ~wclk_ff;
  assign rd_edge = read_clock & ~rclk_ff;
  assign strobe_fall = ~offset_load_strobe & strobe_ff;

  // ==========================================================
  // phase and offset
  dcf_phase_e phase_ff, nxt_phase;
  logic [OW-1:0] stored_x_ff, nxt_stored_x, active_x_ff, nxt_active_x;
  logic [1:0] rst_wedges_ff, nxt_rst_wedges, rst_redges_ff, nxt_rst_redges;
  always_comb begin
    nxt_phase = phase_ff;
    nxt_stored_x = stored_x_ff;
    nxt_active_x = active_x_ff;
    nxt_rst_wedges = rst_wedges_ff;
    nxt_rst_redges = rst_redges_ff;
    if (strobe_fall) begin
      nxt_stored_x = write_data_bus[`DCF_OFS_LSB +: OW];
    end else if (reg_wr && reg_addr == `DCF_REG_OFFSET) begin
      nxt_stored_x = reg_wdata[`DCF_OF_STORED_LSB +: OW];
    end
    if (!fifo_rst_n) begin
      nxt_phase = PH_RESET;
      if (wr_edge && rst_wedges_ff != 2'h3) nxt_rst_wedges = rst_wedges_ff + 2'h1;
      if (rd_edge && rst_redges_ff != 2'h3) nxt_rst_redges = rst_redges_ff + 2'h1;
    end else begin
      nxt_rst_wedges = 2'h0;
      nxt_rst_redges = 2'h0;
      case (phase_ff)
        PH_RESET: begin
          nxt_phase = PH_RUN;
          // stored offset survives resets while the strobe stays low
          nxt_active_x = offset_load_strobe ? OW'(`DCF_OFS_DEFAULT) : stored_x_ff;
        end
        PH_IDLE: nxt_phase = PH_IDLE;
        PH_RUN: nxt_phase = PH_RUN;
        default: nxt_phase = PH_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      phase_ff <= PH_IDLE;
      stored_x_ff <= `DCF_OFS_DEFAULT;
      active_x_ff <= `DCF_OFS_DEFAULT;
      rst_wedges_ff <= 2'h0;
      rst_redges_ff <= 2'h0;
    end else begin
      phase_ff <= nxt_phase;
      stored_x_ff <= nxt_stored_x;
      active_x_ff <= nxt_active_x;
      rst_wedges_ff <= nxt_rst_wedges;
      rst_redges_ff <= nxt_rst_redges;
    end
  end

  // ==========================================================
  // pointers, level and output word
  // both sides live on mclk, so the level needs no domain crossing
  logic [PW-1:0] wptr_ff, nxt_wptr, rptr_ff, nxt_rptr;
  logic [LW-1:0] mem_cnt_ff, nxt_mem_cnt, level_ff, nxt_level;
  logic [WIDTH-1:0] mem_rdata, data_ff, nxt_data;
  logic avail_ff, nxt_avail;
  logic [1:0] avail_pipe_ff, nxt_avail_pipe;
  logic running, wr_take, rd_take, load_word, mem_has;

  assign running = (phase_ff == PH_RUN) && fifo_rst_n;
  assign mem_has = (mem_cnt_ff != '0);
  assign wr_take = running && wr_edge && write_room_flag && write_enable_a && write_enable_b;
  assign rd_take = running && rd_edge && avail_ff && out_drive_en && read_enable_a && read_enable_b;
  // first word goes out on the third read edge whatever the read enables say
  assign load_word = mem_has && ((rd_take) || (running && rd_edge && !avail_ff && avail_pipe_ff[1]));

  always_comb begin
    nxt_wptr = wptr_ff;
    nxt_rptr = rptr_ff;
    nxt_mem_cnt = mem_cnt_ff;
    nxt_data = data_ff;
    nxt_avail = avail_ff;
    nxt_avail_pipe = avail_pipe_ff;
    if (!running) begin
      nxt_wptr = '0;
      nxt_rptr = '0;
      nxt_mem_cnt = '0;
      nxt_avail_pipe = 2'b00;
      if (rd_edge && rst_redges_ff == AVAIL_LAST) nxt_avail = 1'b0;
    end else begin
      if (wr_take) nxt_wptr = wptr_ff + PW'(1);
      if (load_word) nxt_rptr = rptr_ff + PW'(1);
      nxt_mem_cnt = mem_cnt_ff + LW'(wr_take) - LW'(load_word);
      if (rd_edge) nxt_avail_pipe = {avail_pipe_ff[0], mem_has};
      if (load_word) begin
        nxt_data = mem_rdata;
        nxt_avail = 1'b1;
      end else if (rd_take) begin
        nxt_avail = 1'b0;
        nxt_avail_pipe = 2'b00;
      end
    end
    nxt_level = nxt_mem_cnt + LW'(nxt_avail);
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      wptr_ff <= '0;
      rptr_ff <= '0;
      mem_cnt_ff <= '0;
      level_ff <= '0;
      data_ff <= '0;
      avail_ff <= 1'b0;
      avail_pipe_ff <= 2'b00;
    end else begin
      wptr_ff <= nxt_wptr;
      rptr_ff <= nxt_rptr;
      mem_cnt_ff <= nxt_mem_cnt;
      level_ff <= nxt_level;
      data_ff <= nxt_data;
      avail_ff <= nxt_avail;
      avail_pipe_ff <= nxt_avail_pipe;
    end
  end

  dcf_mem #(
    .WIDTH(WIDTH),
    .DEPTH(DEPTH)
  ) u_mem (
    .mclk(mclk),
    .wr_en(wr_take),
    .wr_addr(wptr_ff),
    .wr_data(write_data_bus),
    .rd_addr(rptr_ff),
    .rd_data(mem_rdata)
  );

  // ==========================================================
  // flags
  logic room_pipe_ff, nxt_room_pipe, room_ff, nxt_room;
  logic half_ff, nxt_half, almost_ff, nxt_almost, oe_ff, nxt_oe;
  logic room_target, full_nxt;
  logic [LW-1:0] lo_lim, hi_lim;

  assign full_nxt = (nxt_level == DEPTH_L);
  assign room_target = running && !full_nxt;
  assign lo_lim = LW'(active_x_ff) + LW'(1);
  assign hi_lim = DEPTH_L + LW'(1) - LW'(active_x_ff);

  always_comb begin
    nxt_room_pipe = room_pipe_ff;
    nxt_room = room_ff;
    // rises late through two write edges, but falls at once on full
    if (wr_edge) begin
      nxt_room_pipe = room_target;
      nxt_room = room_pipe_ff;
    end
    if (full_nxt) begin
      nxt_room_pipe = 1'b0;
      nxt_room = 1'b0;
    end
    nxt_half = (nxt_level >= HALF_L);
    nxt_almost = (nxt_level <= lo_lim) || (nxt_level >= hi_lim);
    nxt_oe = out_drive_en;
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      room_pipe_ff <= 1'b0;
      room_ff <= 1'b0;
      half_ff <= 1'b0;
      almost_ff <= 1'b1;
      oe_ff <= 1'b0;
    end else begin
      room_pipe_ff <= nxt_room_pipe;
      room_ff <= nxt_room;
      half_ff <= nxt_half;
      almost_ff <= nxt_almost;
      oe_ff <= nxt_oe;
    end
  end

  assign write_room_flag = room_ff;
  assign read_avail_flag = avail_ff;
  assign half_level_flag = half_ff;
  assign almost_boundary_flag = almost_ff;
  assign read_data_bus = data_ff;
  assign read_data_oe = oe_ff;

  // ==========================================================
  // register port, read data one cycle after the strobe
  logic [`DCF_DATA_W-1:0] rdata_ff, nxt_rdata;

  always_comb begin
    nxt_rdata = '0;
    if (reg_rd) begin
      case (reg_addr)
        `DCF_REG_STATUS: begin
          nxt_rdata[`DCF_ST_ROOM] = room_ff;
          nxt_rdata[`DCF_ST_AVAIL] = avail_ff;
          nxt_rdata[`DCF_ST_HALF] = half_ff;
          nxt_rdata[`DCF_ST_ALMOST] = almost_ff;
          nxt_rdata[`DCF_ST_LEVEL_LSB +: LW] = level_ff;
          nxt_rdata[`DCF_ST_PHASE_LSB +: 2] = phase_ff;
        end
        `DCF_REG_OFFSET: begin
          nxt_rdata[`DCF_OF_STORED_LSB +: OW] = stored_x_ff;
          nxt_rdata[`DCF_OF_ACTIVE_LSB +: OW] = active_x_ff;
        end
        default: nxt_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rdata_ff <= '0;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign reg_rdata = rdata_ff;

  // ==========================================================
  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  sequence s_release_low;
    phase_ff == PH_RESET && fifo_rst_n && !offset_load_strobe;
  endsequence
  sequence s_release_high;
    phase_ff == PH_RESET && fifo_rst_n && offset_load_strobe;
  endsequence

  a_room_when_full: assert property (level_ff == DEPTH_L |-> !write_room_flag)
    else $error("write room flag high while full");
  a_half_level: assert property (half_level_flag == (level_ff >= HALF_L))
    else $error("half flag disagrees with level");
  a_almost_bound: assert property (almost_boundary_flag == ((level_ff <= LW'(active_x_ff) + LW'(1)) ||
      (level_ff >= DEPTH_L + LW'(1) - LW'(active_x_ff))))
    else $error("almost flag disagrees with level");
  a_write_no_over: assert property (wr_take |-> level_ff < DEPTH_L)
    else $error("write taken while full");
  a_read_gated: assert property (rd_take |-> out_drive_en && read_avail_flag && read_enable_a && read_enable_b)
    else $error("read taken without all enables");
  a_offset_take: assert property (strobe_fall |=> stored_x_ff == $past(write_data_bus[OW-1:0]))
    else $error("offset not captured on strobe fall");
  a_offset_keep: assert property (s_release_low |=> active_x_ff == $past(stored_x_ff))
    else $error("stored offset not applied at release");
  a_offset_default: assert property (s_release_high |=> active_x_ff == OW'(`DCF_OFS_DEFAULT))
    else $error("default offset not applied at release");
  a_room_reset: assert property (rst_wedges_ff >= 2'(`DCF_ROOM_EDGES) |-> !write_room_flag)
    else $error("write room flag high after two edges in reset");
  a_avail_empty: assert property (rd_take && !mem_has |=> !read_avail_flag)
    else $error("read available after the last word left");
  a_word_order: assert property (load_word |=> read_data_bus == $past(mem_rdata))
    else $error("output word differs from stored word");
  a_drive_follow: assert property (!out_drive_en |=> !read_data_oe)
    else $error("read data driven while disabled");

endmodule : dcf_top

// file: shared/dcf_defines.svh
// constants for the dual-clock fifo flag block
`ifndef DCF_DEFINES_SVH
`define DCF_DEFINES_SVH

// ==========================================================
// geometry
`define DCF_DEPTH 1024
`define DCF_WIDTH 18
`define DCF_OFS_W 9
`define DCF_OFS_LSB 0
`define DCF_OFS_DEFAULT 9'h100

// ==========================================================
// flag timing, in sampled clock edges
`define DCF_ROOM_EDGES 2
`define DCF_AVAIL_EDGES 3

// ==========================================================
// register port
`define DCF_ADDR_W 4
`define DCF_DATA_W 32
`define DCF_REG_STATUS 4'h0
`define DCF_REG_OFFSET 4'h4
`define DCF_ST_ROOM 0
`define DCF_ST_AVAIL 1
`define DCF_ST_HALF 2
`define DCF_ST_ALMOST 3
`define DCF_ST_LEVEL_LSB 4
`define DCF_ST_PHASE_LSB 16
`define DCF_OF_STORED_LSB 0
`define DCF_OF_ACTIVE_LSB 16

`endif

// file: shared/dcf_pkg.sv
// types shared by the dual-clock fifo flag block
package dcf_pkg;

  // ==========================================================
  // operating phase, gray coded along idle -> reset -> run
  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_RESET = 2'b01,
    PH_RUN = 2'b11
  } dcf_phase_e;

endpackage : dcf_pkg

// file: verif/dcf_far_model.sv
// surrounding system logic: free-running write and read clocks
`timescale 1ns/1ps
module dcf_far_model (
  input wire logic mclk,
  output logic write_clock,
  output logic read_clock
);
  logic [1:0] wcnt_ff = 2'h0;
  logic [2:0] rcnt_ff = 3'h0;

  // ==========================================================
  // clocks
  // periods of 4 and 6 mclk; write rises on even, read on odd cycles,
  // so a write edge never lands in the same cycle as a read edge
  always @(posedge mclk) begin
    wcnt_ff <= wcnt_ff + 2'h1;
    rcnt_ff <= (rcnt_ff == 3'h5) ? 3'h0 : rcnt_ff + 3'h1;
  end
  assign write_clock = wcnt_ff[1];
  assign read_clock = (rcnt_ff >= 3'h3);
endmodule : dcf_far_model

// file: verif/tb_dcf_top.sv
// self-checking bench of the dual-clock fifo flag block
`timescale 1ns/1ps
`include "dcf_defines.svh"
module tb_dcf_top;
  import dcf_pkg::*;
  logic mclk, nrst, fifo_rst_n, offset_load_strobe, out_drive_en;
  logic write_enable_a, write_enable_b, read_enable_a, read_enable_b;
  logic write_clock, read_clock, wc_q, rc_q, reg_wr, reg_rd;
  logic [17:0] write_data_bus, read_data_bus;
  logic read_data_oe, write_room_flag, read_avail_flag, half_level_flag, almost_boundary_flag;
  logic [3:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, d;
  int mismatches = 0;
  int n_checks = 0;

  dcf_top dcf_top_i (.mclk, .nrst, .write_clock, .read_clock, .fifo_rst_n, .offset_load_strobe,
    .write_enable_a, .write_enable_b, .read_enable_a, .read_enable_b, .out_drive_en,
    .write_data_bus, .read_data_bus, .read_data_oe, .write_room_flag, .read_avail_flag,
    .half_level_flag, .almost_boundary_flag, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
  dcf_far_model dcf_far_model_i (.mclk, .write_clock, .read_clock);

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    wc_q <= write_clock;
    rc_q <= read_clock;
  end

  // ==========================================================
  // helpers
  function automatic logic [17:0] pat(input int k);
    return 18'((k * 149) ^ 18'h2a5a5);
  endfunction : pat

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : complete_run

  // returns at the mclk edge where the design samples a rising pin clock
  task automatic edge_wait(input bit rd);
    for (int i = 0; i < 40; i++) begin
      @(posedge mclk);
      if (rd ? (read_clock && !rc_q) : (write_clock && !wc_q)) return;
    end
    mismatches++;
    complete_run();
  endtask : edge_wait

  task automatic reg_access(input logic wr, input logic [3:0] a, input logic [31:0] wd);
    reg_addr <= a;
    reg_wdata <= wd;
    reg_wr <= wr;
    reg_rd <= !wr;
    @(posedge mclk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    @(posedge mclk);
    d = reg_rdata;
  endtask : reg_access

  // ==========================================================
  // scenarios
  task automatic fifo_reset(input logic [8:0] ofs);
    logic room0;
    room0 = write_room_flag;
    fifo_rst_n <= 1'b0;
    edge_wait(1'b0);
    @(posedge mclk);
    check("room reset edge 1", write_room_flag, room0);
    edge_wait(1'b0);
    @(posedge mclk);
    check("room reset edge 2", write_room_flag, 0);
    for (int n = 0; n < 4; n++) edge_wait(1'b1);
    for (int n = 0; n < 5; n++) edge_wait(1'b0);
    check("room in reset", write_room_flag, 0);
    fifo_rst_n <= 1'b1;
    edge_wait(1'b0);
    @(posedge mclk);
    check("room after edge 1", write_room_flag, 0);
    edge_wait(1'b0);
    @(posedge mclk);
    check("room after edge 2", write_room_flag, 1);
    reg_access(1'b0, 4'h4, 32'h0);
    check("active offset", d[24:16], ofs);
    $display("fifo reset with offset %0d done", ofs);
  endtask : fifo_reset

  task automatic fill_drain(input int x);
    int lvl;
    write_enable_a <= 1'b1;
    write_data_bus <= pat(0);
    edge_wait(1'b0);
    edge_wait(1'b0);
    reg_access(1'b0, 4'h0, 32'h0);
    check("level after refused write", d[14:4], 0);
    check("status room", d[`DCF_ST_ROOM], 1);
    check("status phase", d[17:16], PH_RUN);
    write_enable_b <= 1'b1;
    for (int k = 1; k <= 1025; k++) begin
      edge_wait(1'b0);
      write_data_bus <= pat(k);
      @(posedge mclk);
      lvl = (k > 1024) ? 1024 : k;
      check("half", half_level_flag, lvl >= 512);
      check("almost", almost_boundary_flag, lvl <= x + 1 || lvl >= 1025 - x);
      check("room", write_room_flag, lvl < 1024);
    end
    write_enable_a <= 1'b0;
    write_enable_b <= 1'b0;
    read_enable_a <= 1'b1;
    read_enable_b <= 1'b1;
    for (int k = 0; k < 3; k++) edge_wait(1'b1);
    check("oe", read_data_oe, 0);
    check("word held", read_data_bus, pat(0));
    out_drive_en <= 1'b1;
    for (int k = 0; k < 1024; k++) begin
      edge_wait(1'b1);
      lvl = 1024 - k;
      check("avail", read_avail_flag, 1);
      check("read word", read_data_bus, pat(k));
      check("half", half_level_flag, lvl >= 512);
      check("almost", almost_boundary_flag, lvl <= x + 1 || lvl >= 1025 - x);
      if (k == 0) begin
        read_enable_a <= 1'b0;
        check("oe on", read_data_oe, 1);
        edge_wait(1'b0);
        @(posedge mclk);
        check("room edge 1 after read", write_room_flag, 0);
        edge_wait(1'b0);
        @(posedge mclk);
        check("room edge 2 after read", write_room_flag, 1);
        read_enable_a <= 1'b1;
      end
    end
    edge_wait(1'b1);
    @(posedge mclk);
    check("avail empty", read_avail_flag, 0);
    check("almost empty", almost_boundary_flag, 1);
    read_enable_a <= 1'b0;
    read_enable_b <= 1'b0;
    out_drive_en <= 1'b0;
    $display("fill and drain with offset %0d done", x);
  endtask : fill_drain

  // ==========================================================
  // main sequence
  initial begin
    nrst = 1'b0;
    fifo_rst_n = 1'b1;
    offset_load_strobe = 1'b1;
    out_drive_en = 1'b0;
    write_enable_a = 1'b0;
    write_enable_b = 1'b0;
    read_enable_a = 1'b0;
    read_enable_b = 1'b0;
    write_data_bus = 18'h0;
    reg_addr = 4'h0;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (3) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    fifo_reset(9'h100);
    fill_drain(256);
    write_data_bus <= 18'h00005;
    @(posedge mclk);
    offset_load_strobe <= 1'b0;
    @(posedge mclk);
    write_data_bus <= 18'h00077;
    fifo_reset(9'h005);
    fill_drain(5);
    fifo_reset(9'h005);
    reg_access(1'b1, 4'h4, 32'h000001ab);
    reg_access(1'b0, 4'h4, 32'h0);
    check("stored offset", d[8:0], 9'h1ab);
    reg_access(1'b0, 4'h8, 32'h0);
    check("unmapped read", d, 0);
    $display("register port test done");
    complete_run();
  end
endmodule : tb_dcf_top
